/* File: inc/wse_pkg.sv */
// package: register map, field layouts and reset values for the wake block
package wse_pkg;

    localparam int unsigned       WSE_ADDR_W        = 12;
    localparam int unsigned       WSE_DATA_W        = 32;
    localparam int unsigned       WSE_REG_W         = 8;

    // printed offsets are not all multiples of four: index, byte = 4*index
    localparam logic [7:0]        WSE_IDX_PIN_EN    = 8'h0e;
    localparam logic [7:0]        WSE_IDX_PERIPH_EN = 8'h0f;
    localparam logic [7:0]        WSE_IDX_SMI_STS   = 8'h10;
    localparam logic [7:0]        WSE_IDX_CTRL      = 8'h20;
    localparam logic [7:0]        WSE_IDX_IRQ_STS   = 8'h21;
    localparam logic [7:0]        WSE_IDX_IRQ_MASK  = 8'h22;
    localparam logic [7:0]        WSE_IDX_PIN_STS   = 8'h23;

    localparam logic [7:0]        WSE_RST_PIN_EN    = 8'h00;
    localparam logic [7:0]        WSE_RST_PERIPH_EN = 8'h00;
    localparam logic [7:0]        WSE_RST_SMI_STS   = 8'h02;
    localparam logic [7:0]        WSE_SMI_USED_MASK = 8'h9e;

    // peripheral enable bit positions
    localparam int unsigned       WSE_PE_PAR        = 0;
    localparam int unsigned       WSE_PE_SER2       = 1;
    localparam int unsigned       WSE_PE_SER1       = 2;
    localparam int unsigned       WSE_PE_FLOPPY     = 3;
    localparam int unsigned       WSE_PE_MOUSE      = 4;
    localparam int unsigned       WSE_PE_KBD        = 5;
    localparam int unsigned       WSE_PE_WDOG       = 6;
    localparam int unsigned       WSE_PE_SMBUS      = 7;

    // smi status bit positions
    localparam int unsigned       WSE_SS_PAR        = 1;
    localparam int unsigned       WSE_SS_SER2       = 2;
    localparam int unsigned       WSE_SS_SER1       = 3;
    localparam int unsigned       WSE_SS_FLOPPY     = 4;
    localparam int unsigned       WSE_SS_WDOG       = 7;

    // control register fields
    localparam int unsigned       WSE_CT_GLOBAL_EN  = 0;
    localparam int unsigned       WSE_CT_PAR_ACT    = 1;

    // interrupt status fields
    localparam int unsigned       WSE_IS_WAKE       = 0;
    localparam int unsigned       WSE_IS_BUS        = 1;
    localparam int unsigned       WSE_IS_SMI        = 2;
    localparam int unsigned       WSE_IS_W          = 3;

    typedef struct packed {
        logic parallel_port_irq;
        logic serial2_irq;
        logic serial1_irq;
        logic floppy_irq;
        logic mouse_irq;
        logic keyboard_irq;
        logic watchdog_event;
        logic sysmgmt_bus_event;
    } wse_periph_type;

endpackage : wse_pkg

/* File: rtl/wse_wake_smi.sv */
// wake-event enables, peripheral smi status and apb slave
// Summary of operation
// - Wake output asserts when pin enable, status and global enable are 1.
// - Enable 0 keeps a pin in its status but off the wake output.
// - Pin wake enable at index 0x0e gates pins 5_0 to 5_7 with bits 0 to 7.
// - Pin wake enable clears only on standby reset, never on main reset.
// - Peripheral enable at index 0x0f gates eight interrupts onto the bus.
// - The wake status bus asserts only for an enabled, signalling source.
// - Smi status 0x10 holds five sources in bits 1 to 4 and 7.
// - Smi status ignores writes and falls only when its source clears or a reset loads 0x02.
// - Parallel status is 1 while inactive and follows printer acknowledge.
// - Smi status resets to 0x02 on every reset, parallel bit held at 1.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module wse_wake_smi
    import wse_pkg::*;
#(
    parameter int unsigned NUM_PINS = 8
)
(
    // clock and resets
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      standby_power_rst_n,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [wse_pkg::WSE_ADDR_W-1:0] paddr,
    input  wire logic [wse_pkg::WSE_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [wse_pkg::WSE_DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // wake pins, asynchronous
    input  wire logic [NUM_PINS-1:0]       gpio_pin_5,
    // peripheral interrupts, same clock
    input  wire wse_pkg::wse_periph_type   periph_irq,
    input  wire logic                      printer_acknowledge_in,
    // outputs
    output logic                           wake_request_out_n,
    output logic                           internal_wake_status_bus,
    output logic                           irq
);
    import wse_pkg::*;

    // the pin enable register is one byte wide, so no other pin count fits
    if (NUM_PINS != WSE_REG_W)
    begin : g_bad_width
        $error("NUM_PINS must equal the register width");
    end

    logic [NUM_PINS-1:0] pin_sync1;
    logic [NUM_PINS-1:0] pin_sync2;
    logic [NUM_PINS-1:0] pin_sync3;
    logic [NUM_PINS-1:0] pin_sts;
    logic [7:0]          pin_en;
    logic [7:0]          periph_en;
    logic [7:0]          ctrl;
    logic [7:0]          smi_sts;
    logic [WSE_IS_W-1:0] irq_sts;
    logic [WSE_IS_W-1:0] irq_mask;
    logic                wake_q;
    logic                bus_q;
    logic [WSE_DATA_W-1:0] next_prdata;

    // address decode
    wire        acc      = psel & penable;
    wire        wr       = acc & pwrite & pstrb[0];
    wire        rd       = acc & ~pwrite;
    wire        aligned  = (paddr[1:0] == 2'b00);
    wire [7:0]  idx      = paddr[9:2];
    wire        in_range = (paddr[WSE_ADDR_W-1:10] == '0) & aligned;
    wire        sel_pin  = in_range & (idx == WSE_IDX_PIN_EN);
    wire        sel_per  = in_range & (idx == WSE_IDX_PERIPH_EN);
    wire        sel_smi  = in_range & (idx == WSE_IDX_SMI_STS);
    wire        sel_ctl  = in_range & (idx == WSE_IDX_CTRL);
    wire        sel_ist  = in_range & (idx == WSE_IDX_IRQ_STS);
    wire        sel_imk  = in_range & (idx == WSE_IDX_IRQ_MASK);
    wire        sel_pst  = in_range & (idx == WSE_IDX_PIN_STS);
    wire        mapped   = sel_pin | sel_per | sel_smi | sel_ctl
                         | sel_ist | sel_imk | sel_pst;
    wire        global_en = ctrl[WSE_CT_GLOBAL_EN];
    wire        par_act   = ctrl[WSE_CT_PAR_ACT];

    // a change counts once second and third stages agree
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_sync1[g] <= 1'b0;
                    pin_sync2[g] <= 1'b0;
                    pin_sync3[g] <= 1'b0;
                    pin_sts[g]   <= 1'b0;
                end
                else
                begin
                    pin_sync1[g] <= gpio_pin_5[g];
                    pin_sync2[g] <= pin_sync1[g];
                    pin_sync3[g] <= pin_sync2[g];
                    if (pin_sync2[g] == pin_sync3[g])
                        pin_sts[g] <= pin_sync3[g];
                end
            end
        end
    endgenerate

    // wake request and internal bus
    wire wake_now = global_en & |(pin_en & pin_sts);
    wire [7:0] periph_vec = {periph_irq.sysmgmt_bus_event,
                             periph_irq.watchdog_event,
                             periph_irq.keyboard_irq,
                             periph_irq.mouse_irq,
                             periph_irq.floppy_irq,
                             periph_irq.serial1_irq,
                             periph_irq.serial2_irq,
                             periph_irq.parallel_port_irq};
    wire bus_now = |(periph_en & periph_vec);

    // parallel bit is 1 while the port is inactive
    wire par_bit = par_act ? printer_acknowledge_in : 1'b1;
    wire [7:0] next_smi = {periph_irq.watchdog_event, 2'b00,
                           periph_irq.floppy_irq,
                           periph_irq.serial1_irq,
                           periph_irq.serial2_irq,
                           par_bit, 1'b0};

    // standby-power domain: survives presetn
    always_ff @(posedge pclk or negedge standby_power_rst_n)
    begin
        if (!standby_power_rst_n)
            pin_en <= WSE_RST_PIN_EN;
        else if (wr & sel_pin)
            pin_en <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_en <= WSE_RST_PERIPH_EN;
            ctrl      <= 8'h00;
            irq_mask  <= '0;
        end
        else if (wr)
        begin
            if (sel_per)
                periph_en <= pwdata[7:0];
            if (sel_ctl)
                ctrl <= pwdata[7:0];
            if (sel_imk)
                irq_mask <= pwdata[WSE_IS_W-1:0];
        end
    end

    // mirrors sources; writes have no effect
    // either reset restores the parallel bit, so both reach this register
    wire smi_rst_n = presetn & standby_power_rst_n;
    always_ff @(posedge pclk or negedge smi_rst_n)
    begin
        if (!smi_rst_n)
            smi_sts <= WSE_RST_SMI_STS;
        else
            smi_sts <= next_smi & WSE_SMI_USED_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_q <= 1'b0;
            bus_q  <= 1'b0;
        end
        else
        begin
            wake_q <= wake_now;
            bus_q  <= bus_now;
        end
    end

    // sticky events: rising wake, rising bus, smi change; read clears,
    // a new event in the clearing cycle wins
    wire [WSE_IS_W-1:0] evt;
    assign evt[WSE_IS_WAKE] = wake_now & ~wake_q;
    assign evt[WSE_IS_BUS]  = bus_now & ~bus_q;
    assign evt[WSE_IS_SMI]  = |((next_smi & WSE_SMI_USED_MASK) ^ smi_sts);
    wire rd_clr = rd & sel_ist;
    // clear only what the setup cycle copied into prdata: an event that
    // lands at the setup edge would otherwise vanish unread
    wire [WSE_IS_W-1:0] clr_bits = rd_clr ? prdata[WSE_IS_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_sts <= '0;
        else
            irq_sts <= (irq_sts & ~clr_bits) | evt;
    end

    // read data
    always_comb
    begin
        next_prdata = '0;
        if (sel_pin)
            next_prdata[7:0] = pin_en;
        else if (sel_per)
            next_prdata[7:0] = periph_en;
        else if (sel_smi)
            next_prdata[7:0] = smi_sts;
        else if (sel_ctl)
            next_prdata[7:0] = ctrl;
        else if (sel_ist)
            next_prdata[WSE_IS_W-1:0] = irq_sts;
        else if (sel_imk)
            next_prdata[WSE_IS_W-1:0] = irq_mask;
        else if (sel_pst)
            next_prdata[NUM_PINS-1:0] = pin_sts;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel & ~penable & ~pwrite)
            prdata <= next_prdata;
    end

    // zero wait states; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_request_out_n       <= 1'b1;
            internal_wake_status_bus <= 1'b0;
            irq                      <= 1'b0;
        end
        else
        begin
            wake_request_out_n       <= ~wake_now;
            internal_wake_status_bus <= bus_now;
            irq                      <= |(irq_sts & irq_mask);
        end
    end

    chk_wake_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        (global_en && |(pin_en & pin_sts)) |=> !wake_request_out_n)
        else $error("wake output not driven for enabled pin");
    chk_wake_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(|(pin_en & pin_sts)) |=> wake_request_out_n)
        else $error("wake output driven without enabled pin");
    chk_bus_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        (periph_en == 8'h00) |=> !internal_wake_status_bus)
        else $error("wake bus asserted with all enables 0");
    chk_bus_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        |(periph_en & periph_vec) |=> internal_wake_status_bus)
        else $error("wake bus missed enabled source");
    chk_smi_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (smi_sts & ~WSE_SMI_USED_MASK) == 8'h00)
        else $error("reserved smi bits set");
    chk_smi_nowrite: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && sel_smi) |=> smi_sts == (($past(next_smi)) & WSE_SMI_USED_MASK))
        else $error("smi status changed by write");
    chk_smi_reset: assert property (
        @(posedge pclk)
        $rose(presetn) |-> smi_sts == WSE_RST_SMI_STS)
        else $error("smi status not at reset value after reset");
    chk_par_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        !par_act |=> smi_sts[WSE_SS_PAR])
        else $error("parallel bit low while inactive");
    chk_par_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        par_act |=> smi_sts[WSE_SS_PAR] == $past(printer_acknowledge_in))
        else $error("parallel bit not following acknowledge");
    chk_pin_en_clear: assert property (
        @(posedge pclk)
        $rose(standby_power_rst_n) |-> pin_en == WSE_RST_PIN_EN)
        else $error("pin enable not cleared by standby reset");
    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        |(irq_sts & irq_mask) |=> irq)
        else $error("interrupt output missed pending status");
    chk_pin_en_keep: assert property (@(posedge pclk)
        disable iff (!standby_power_rst_n)
        !(wr && sel_pin) |=> $stable(pin_en))
        else $error("pin enable changed without write");

    cov_wake: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(wake_request_out_n));
    cov_bus: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(internal_wake_status_bus));
    cov_irq: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq) ##[1:20] !irq);
    cov_par_follow: cover property (@(posedge pclk) disable iff (!presetn)
        par_act && !smi_sts[WSE_SS_PAR]);

endmodule : wse_wake_smi

`default_nettype wire

/* File: testbench/tb.sv */
// testbench: register, wake, smi status and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none

module tb;
    import wse_pkg::*;
    logic           pclk, presetn, standby_power_rst_n;
    logic           psel, penable, pwrite, printer_acknowledge_in;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, q;
    logic [3:0]     pstrb;
    logic           pready, pslverr, wake_request_out_n;
    logic           internal_wake_status_bus, irq, wake_seen, err, act;
    logic [7:0]     gpio_pin_5, en, pv;
    wse_periph_type periph_irq;
    int             errors, compares;

    wse_wake_smi wse_wake_smi_i (.pclk, .presetn, .standby_power_rst_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .gpio_pin_5, .periph_irq,
        .printer_acknowledge_in, .wake_request_out_n,
        .internal_wake_status_bus, .irq);
    wse_pm_model wse_pm_model_i (.pclk, .presetn, .wake_request_out_n,
        .wake_seen);

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_of_test;
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // master holds every qualifier until pready is seen high
    task automatic apb(logic wr, logic [7:0] idx, logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            end_of_test();
        end
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(string nm, logic [7:0] idx, logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(nm, exp, q);
    endtask : rchk

    function automatic logic bus_exp(logic [7:0] e, logic [7:0] p);
        logic [7:0] r;
        r = {<<{p}};
        return |(e & r);
    endfunction : bus_exp

    function automatic logic [31:0] smi_exp(logic a, logic k,
                                            logic [7:0] p);
        logic [31:0] s;
        s = 32'h0;
        s[1] = a ? k : 1'b1;
        s[2] = p[6];
        s[3] = p[5];
        s[4] = p[4];
        s[7] = p[1];
        return s;
    endfunction : smi_exp

    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_of_test();
    end

    initial
    begin
        errors = 0;
        compares = 0;
        {presetn, standby_power_rst_n, psel, penable, pwrite} = '0;
        {paddr, pwdata, gpio_pin_5, printer_acknowledge_in} = '0;
        periph_irq = '0;
        pstrb = 4'hf;
        void'($urandom(32));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        standby_power_rst_n <= 1'b1;
        rchk("pin_en", WSE_IDX_PIN_EN, 32'h0);
        rchk("periph_en", WSE_IDX_PERIPH_EN, 32'h0);
        rchk("smi_sts", WSE_IDX_SMI_STS, 32'h2);
        apb(1'b0, 8'h11, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        en = 8'($urandom);
        apb(1'b1, WSE_IDX_PIN_EN, {24'h0, en});
        rchk("pin_en", WSE_IDX_PIN_EN, {24'h0, en});
        pstrb <= 4'he;
        apb(1'b1, WSE_IDX_PIN_EN, {24'h0, ~en});
        pstrb <= 4'hf;
        rchk("pin_en", WSE_IDX_PIN_EN, {24'h0, en});
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rchk("pin_en", WSE_IDX_PIN_EN, {24'h0, en});
        rchk("smi_sts", WSE_IDX_SMI_STS, 32'h2);
        standby_power_rst_n <= 1'b0;
        @(posedge pclk);
        standby_power_rst_n <= 1'b1;
        rchk("pin_en", WSE_IDX_PIN_EN, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            en = (i == 1) ? 8'h01 : 8'($urandom);
            pv = (i == 0) ? ~en : (i == 1) ? 8'h01 : 8'($urandom);
            apb(1'b1, WSE_IDX_CTRL, {31'h0, i != 7});
            apb(1'b1, WSE_IDX_PIN_EN, {24'h0, en});
            gpio_pin_5 <= pv;
            repeat (6) @(posedge pclk);
            chk("wake_n", {31'h0, !(i != 7 && |(en & pv))},
                {31'h0, wake_request_out_n});
            rchk("pin_sts", WSE_IDX_PIN_STS, {24'h0, pv});
        end
        chk("wake_seen", 32'h1, {31'h0, wake_seen});
        for (int i = 0; i < 10; i++)
        begin
            en = (i == 0) ? 8'h00 : 8'($urandom);
            pv = (i == 0) ? 8'hff : 8'($urandom);
            act = i[0];
            apb(1'b1, WSE_IDX_PERIPH_EN, {24'h0, en});
            apb(1'b1, WSE_IDX_CTRL, {30'h0, act, 1'b0});
            periph_irq <= wse_periph_type'(pv);
            printer_acknowledge_in <= 1'($urandom);
            repeat (3) @(posedge pclk);
            chk("wake_bus", {31'h0, bus_exp(en, pv)},
                {31'h0, internal_wake_status_bus});
            apb(1'b1, WSE_IDX_SMI_STS, 32'hff);
            rchk("smi_sts", WSE_IDX_SMI_STS,
                 smi_exp(act, printer_acknowledge_in, pv));
        end
        periph_irq <= '0;
        apb(1'b1, WSE_IDX_PERIPH_EN, 32'h01);
        apb(1'b1, WSE_IDX_IRQ_MASK, 32'h2);
        apb(1'b0, WSE_IDX_IRQ_STS, 32'h0);
        rchk("irq_clr", WSE_IDX_IRQ_STS, 32'h0);
        periph_irq <= wse_periph_type'(8'h80);
        for (int n = 0; n < 10 && irq !== 1'b1; n++)
            @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        if (irq !== 1'b1)
            end_of_test();
        apb(1'b0, WSE_IDX_IRQ_STS, 32'h0);
        chk("irq_sts", 32'h1, {31'h0, q[1]});
        repeat (2) @(posedge pclk);
        chk("irq_low", 32'h0, {31'h0, irq});
        periph_irq <= '0;
        apb(1'b1, WSE_IDX_IRQ_MASK, 32'h0);
        rchk("irq_clr", WSE_IDX_IRQ_STS, 32'h0);
        periph_irq <= wse_periph_type'(8'h80);
        repeat (6) @(posedge pclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        end_of_test();
    end
endmodule : tb

`default_nettype wire

/* File: testbench/wse_pm_model.sv */
// partner: power-management logic that latches wake requests
`timescale 1ns/1ps
`default_nettype none

module wse_pm_model
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // wake request from the block
    input  wire logic wake_request_out_n,
    // latched request, held until reset
    output logic      wake_seen
);
    // latched so a short request is not lost between polls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_seen <= 1'b0;
        else if (!wake_request_out_n)
            wake_seen <= 1'b1;
    end
endmodule : wse_pm_model

`default_nettype wire
